//--- rtl/eag_top.sv
// eag_top: working-register file, stack pointer checks and address forming
// assumes decoder issues at most one request per cycle; stack ops not mixed with requests
// Summary of operation
// - stack pointer addresses next free word
// - push writes then increments; pop decrements first
// - call push zero-extends upper program counter
// - exception push packs status byte with counter
// - stack limit bit zero forced to zero
// - stack limit not set by reset
// - stack-pointer addresses compared against stack limit
// - push at limit fine; next push traps
// - trap when stack pointer below data RAM
// - file direct uses 13-bit byte address
// - three-operand: register, memory word or 5-bit literal
// - indirect, post, pre and offset address forming
// - move shares one 4-bit offset field
// - move adds indexed, 8- and 16-bit literals
// - dual-operand prefetch uses registers 8 to 11
// - indexed prefetch only via registers 9, 11
// - prefetch: indirect, post by 2/4/6, indexed
// - Y circular addresses keep bit zero clear
// - one circular buffer each in X and Y
// - buffers of any length checked at both bounds
// - buffer bounded by 16-bit start and end
// - X selection fifteen disables X circular addressing
// - corrected address written back only pre/post

`timescale 1ns/1ps

module eag_top (
	input  wire logic              clk_sys_i,
	input  wire logic              sys_rst_i,
	input  wire eag_pkg::eag_req_s req_i,
	input  wire eag_pkg::eag_stk_e stk_op_i,
	input  wire logic              stk_call_i,
	input  wire logic              stk_exc_i,
	input  wire logic [22:0]       pc_i,
	input  wire logic [7:0]        status_low_byte_i,
	input  wire logic              reg_wr_i,
	input  wire logic [3:0]        reg_wr_idx_i,
	input  wire logic [15:0]       reg_wr_data_i,
	input  wire logic              stack_limit_wr_i,
	input  wire logic [15:0]       stack_limit_data_i,
	input  wire logic              circ_wr_i,
	input  wire logic [1:0]        circ_wr_sel_i,
	input  wire logic [15:0]       circ_wr_data_i,
	input  wire logic              x_circ_en_i,
	input  wire logic              y_circ_en_i,
	input  wire logic [3:0]        x_circ_pointer_select_i,
	input  wire logic [3:0]        y_circ_pointer_select_i,
	output eag_pkg::eag_rsp_s      rsp_o,
	output logic                   stk_wr_o,
	output logic                   stk_rd_o,
	output logic [15:0]            stk_addr_o,
	output logic [15:0]            stk_data_o,
	output logic                   stack_trap_o,
	output logic                   req_reject_o,
	output logic [15:0]            stack_pointer_reg_o,
	output logic [15:0]            stack_limit_reg_o
);

	logic [15:0] pointer_reg_q [16];
	logic [15:0] stack_limit_reg_q;
	logic [15:0] x_circ_start_q;
	logic [15:0] x_circ_end_q;
	logic [15:0] y_circ_start_q;
	logic [15:0] y_circ_end_q;
	logic [3:0]  x_sel_q;
	logic [3:0]  y_sel_q;
	logic        x_en_q;
	logic        y_en_q;
	eag_pkg::eag_rsp_s rsp_d;
	eag_pkg::eag_rsp_s rsp_q;
	logic        trap_d;
	logic        reject_d;
	logic [15:0] sp_cur;

	// signed modifier: literal low bits, sign taken from bit 4
	function automatic logic [15:0] sext5(input logic [15:0] v);
		sext5 = {{11{v[4]}}, v[4:0]};
	endfunction : sext5

	// circular wrap on either bound; start/end are inclusive
	function automatic logic [15:0] wrap(input logic [15:0] a, input logic [15:0] s,
		input logic [15:0] e, input logic word_only);
		logic [15:0] len;
		logic [15:0] r;
		len = e - s + 16'h0001;
		r   = a;
		if (a > e) begin
			r = a - len;
		end else if (a < s) begin
			r = a + len;
		end
		wrap = word_only ? {r[15:1], 1'b0} : r;
	endfunction : wrap

	assign sp_cur = pointer_reg_q[eag_pkg::SP_IDX];

	// register file and stack pointer; stack ops take precedence for the pointer
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 16; i++) begin
				pointer_reg_q[i] <= 16'h0000;
			end
			pointer_reg_q[eag_pkg::SP_IDX] <= eag_pkg::SP_RST;
		end else begin
			if (reg_wr_i) begin
				pointer_reg_q[reg_wr_idx_i] <= reg_wr_data_i;
			end
			if (rsp_d.wb_en) begin
				pointer_reg_q[rsp_d.wb_idx] <= rsp_d.wb_val;
			end
			if (stk_op_i == eag_pkg::EAG_STK_PUSH) begin
				pointer_reg_q[eag_pkg::SP_IDX] <= sp_cur + 16'h0002;
			end else if (stk_op_i == eag_pkg::EAG_STK_POP) begin
				pointer_reg_q[eag_pkg::SP_IDX] <= sp_cur - 16'h0002;
			end
		end
	end

	// limit has no reset value; software must write it before relying on traps
	always_ff @(posedge clk_sys_i) begin
		if (stack_limit_wr_i) begin
			stack_limit_reg_q <= {stack_limit_data_i[15:1], 1'b0};
		end
	end

	// one start/end pair per space
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			x_circ_start_q <= eag_pkg::CIRC_RST;
			x_circ_end_q   <= eag_pkg::CIRC_RST;
			y_circ_start_q <= eag_pkg::CIRC_RST;
			y_circ_end_q   <= eag_pkg::CIRC_RST;
		end else if (circ_wr_i) begin
			unique case (circ_wr_sel_i)
				2'h0: x_circ_start_q <= circ_wr_data_i;
				2'h1: x_circ_end_q   <= circ_wr_data_i;
				2'h2: y_circ_start_q <= circ_wr_data_i;
				2'h3: y_circ_end_q   <= circ_wr_data_i;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			x_sel_q <= eag_pkg::CIRC_SEL_RST;
			y_sel_q <= eag_pkg::CIRC_SEL_RST;
			x_en_q  <= 1'b0;
			y_en_q  <= 1'b0;
		end else begin
			x_sel_q <= x_circ_pointer_select_i;
			y_sel_q <= y_circ_pointer_select_i;
			x_en_q  <= x_circ_en_i;
			y_en_q  <= y_circ_en_i;
		end
	end

	// address forming
	always_comb begin
		logic [15:0] base;
		logic [15:0] ea;
		logic [15:0] newp;
		logic        modify;
		logic        circ;
		logic        y_sp;
		logic        sp_ea;
		base     = pointer_reg_q[req_i.ptr];
		circ     = 1'b0;
		sp_ea    = 1'b0;
		ea       = base;
		newp     = base;
		modify   = 1'b0;
		y_sp     = req_i.y_space;
		reject_d = 1'b0;
		rsp_d    = '0;
		rsp_d.valid = req_i.valid;
		unique case (req_i.mode)
			eag_pkg::EAG_AM_DIRECT: ea = base;
			eag_pkg::EAG_AM_FILE: ea = {3'h0, req_i.faddr};
			eag_pkg::EAG_AM_IND: ea = base;
			eag_pkg::EAG_AM_POST: begin
				ea     = base;
				newp   = base + sext5(req_i.lit);
				modify = 1'b1;
			end
			eag_pkg::EAG_AM_PRE: begin
				ea     = base + sext5(req_i.lit);
				newp   = ea;
				modify = 1'b1;
			end
			eag_pkg::EAG_AM_REGOFF: ea = base + pointer_reg_q[req_i.offs];
			eag_pkg::EAG_AM_LITOFF: ea = base + req_i.lit;
			eag_pkg::EAG_AM_LIT5: begin
				rsp_d.lit_valid = 1'b1;
				rsp_d.lit_val   = {11'h000, req_i.lit[4:0]};
			end
			eag_pkg::EAG_AM_LIT8: begin
				rsp_d.lit_valid = 1'b1;
				rsp_d.lit_val   = {8'h00, req_i.lit[7:0]};
			end
			eag_pkg::EAG_AM_LIT16: begin
				rsp_d.lit_valid = 1'b1;
				rsp_d.lit_val   = req_i.lit;
			end
			eag_pkg::EAG_AM_DSP: begin
				// lit[1:0]: 0 plain, 1..3 post by 2/4/6; lit[2] indexed
				y_sp = req_i.ptr[1];
				if (req_i.ptr[3:2] != 2'b10) begin
					reject_d = 1'b1;
				end else if (req_i.lit[2]) begin
					if (!req_i.ptr[0]) begin
						reject_d = 1'b1;
					end
					ea = base + pointer_reg_q[req_i.offs];
				end else if (req_i.lit[1:0] != 2'b00) begin
					newp   = base + {13'h0000, req_i.lit[1:0], 1'b0};
					modify = 1'b1;
				end
			end
			default: reject_d = 1'b1;
		endcase
		sp_ea = (req_i.ptr == eag_pkg::SP_IDX);
		// stack pointer is never a circular pointer
		circ = !sp_ea && (y_sp ? (y_en_q && y_sel_q != eag_pkg::CIRC_OFF_SEL && req_i.ptr == y_sel_q)
			: (x_en_q && x_sel_q != eag_pkg::CIRC_OFF_SEL && req_i.ptr == x_sel_q));
		if (circ && req_i.mode != eag_pkg::EAG_AM_FILE && req_i.mode != eag_pkg::EAG_AM_DIRECT) begin
			if (y_sp) begin
				ea   = wrap(ea, y_circ_start_q, y_circ_end_q, 1'b1);
				newp = wrap(newp, y_circ_start_q, y_circ_end_q, 1'b1);
			end else begin
				ea   = wrap(ea, x_circ_start_q, x_circ_end_q, 1'b0);
				newp = wrap(newp, x_circ_start_q, x_circ_end_q, 1'b0);
			end
		end
		rsp_d.ea     = ea;
		rsp_d.wb_en  = req_i.valid && !reject_d && modify;
		rsp_d.wb_idx = req_i.ptr;
		rsp_d.wb_val = newp;
		if (reject_d) begin
			rsp_d.valid = 1'b0;
		end
		trap_d = 1'b0;
		// only pointer-based modes form an address from the stack pointer
		if (req_i.valid && !reject_d && sp_ea
			&& req_i.mode inside {eag_pkg::EAG_AM_IND, eag_pkg::EAG_AM_POST, eag_pkg::EAG_AM_PRE,
			eag_pkg::EAG_AM_REGOFF, eag_pkg::EAG_AM_LITOFF}
			&& (ea > stack_limit_reg_q || ea < eag_pkg::RAM_START)) begin
			trap_d = 1'b1;
		end
		if (stk_op_i == eag_pkg::EAG_STK_PUSH && sp_cur > stack_limit_reg_q) begin
			trap_d = 1'b1;
		end
		// compared before subtracting so a tiny pointer cannot wrap past the check
		if (stk_op_i == eag_pkg::EAG_STK_POP && sp_cur < (eag_pkg::RAM_START + 16'h0002)) begin
			trap_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rsp_q <= '0;
		end else begin
			rsp_q <= rsp_d;
		end
	end

	// trap pulse is combinational: it lands with stk_addr_o, one cycle before rsp_o carries the offending ea
	assign stack_trap_o = trap_d;
	assign req_reject_o = req_i.valid && reject_d;
	assign rsp_o        = rsp_q;

	// stack memory side
	always_comb begin
		stk_wr_o   = (stk_op_i == eag_pkg::EAG_STK_PUSH);
		stk_rd_o   = (stk_op_i == eag_pkg::EAG_STK_POP);
		stk_addr_o = stk_rd_o ? (sp_cur - 16'h0002) : sp_cur;
		stk_data_o = 16'h0000;
		if (stk_exc_i) begin
			stk_data_o = {status_low_byte_i, 1'b0, pc_i[22:16]};
		end else if (stk_call_i) begin
			stk_data_o = {9'h000, pc_i[22:16]};
		end
	end

	assign stack_pointer_reg_o = sp_cur;
	assign stack_limit_reg_o   = stack_limit_reg_q;

	chk_push_grows: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(stk_op_i == eag_pkg::EAG_STK_PUSH && !reg_wr_i) |=> sp_cur == $past(sp_cur) + 16'h0002)
		else $error("push did not advance stack pointer");
	chk_pop_shrinks: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(stk_op_i == eag_pkg::EAG_STK_POP && !reg_wr_i) |=> sp_cur == $past(sp_cur) - 16'h0002)
		else $error("pop did not lower stack pointer");
	chk_call_msb: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(stk_call_i && !stk_exc_i && stk_wr_o) |-> stk_data_o[15:7] == 9'h000)
		else $error("call push upper bits not clear");
	chk_exc_status: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		stk_exc_i |-> stk_data_o[15:8] == status_low_byte_i)
		else $error("exception push lacks status byte");
	chk_limit_align: assert property (@(posedge clk_sys_i)
		stack_limit_wr_i |=> stack_limit_reg_q[0] == 1'b0)
		else $error("stack limit bit zero set");
	chk_push_trap: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(stk_op_i == eag_pkg::EAG_STK_PUSH && sp_cur == stack_limit_reg_q
		 && !(req_i.valid && req_i.ptr == eag_pkg::SP_IDX)) |-> !stack_trap_o)
		else $error("trap raised at limit");
	chk_underflow: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(stk_op_i == eag_pkg::EAG_STK_POP && sp_cur < 16'h0802) |-> stack_trap_o)
		else $error("underflow not trapped");
	chk_offset_nowb: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(req_i.mode inside {eag_pkg::EAG_AM_REGOFF, eag_pkg::EAG_AM_LITOFF}) |=> !rsp_q.wb_en)
		else $error("offset mode wrote pointer back");
	chk_dsp_range: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(req_i.valid && req_i.mode == eag_pkg::EAG_AM_DSP && req_i.ptr[3:2] != 2'b10) |-> req_reject_o)
		else $error("prefetch outside 8..11 accepted");

	// accepted request, and a plain indirect request through the stack pointer
	sequence s_req_ok;
		req_i.valid && !req_reject_o;
	endsequence
	sequence s_sp_ind_req;
		req_i.valid && req_i.ptr == eag_pkg::SP_IDX && req_i.mode == eag_pkg::EAG_AM_IND;
	endsequence
	chk_rsp_follows: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		s_req_ok |=> rsp_q.valid)
		else $error("accepted request gave no response");
	chk_reject_quiet: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(req_i.valid && req_reject_o) |=> (!rsp_q.valid && !rsp_q.wb_en))
		else $error("refused request still answered");
	chk_dsp_index: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(req_i.valid && req_i.mode == eag_pkg::EAG_AM_DSP && req_i.lit[2] && !req_i.ptr[0])
		|-> req_reject_o)
		else $error("indexed prefetch through even pointer accepted");
	chk_file_near: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(s_req_ok ##0 req_i.mode == eag_pkg::EAG_AM_FILE) |=> rsp_q.ea[15:13] == 3'h0)
		else $error("file address left the near space");
	chk_lit_flag: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(s_req_ok ##0 req_i.mode inside {eag_pkg::EAG_AM_LIT5, eag_pkg::EAG_AM_LIT8, eag_pkg::EAG_AM_LIT16})
		|=> rsp_q.lit_valid)
		else $error("literal operand not flagged");
	chk_sp_limit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(s_sp_ind_req ##0 sp_cur > stack_limit_reg_q) |-> stack_trap_o)
		else $error("stack pointer address above limit not trapped");

endmodule : eag_top

//--- rtl/eag_pkg.sv
// eag_pkg: constants, enums and carrier structs for the effective-address generator
// assumes a 16-bit data space with byte addresses and word-aligned stack

package eag_pkg;

	localparam int unsigned DW            = 16;
	localparam logic [15:0] RAM_START     = 16'h0800;
	localparam logic [15:0] SP_RST        = 16'h0800;
	localparam logic [3:0]  SP_IDX        = 4'hF;
	localparam logic [3:0]  CIRC_OFF_SEL  = 4'hF;
	localparam logic [3:0]  XPF_A_IDX     = 4'h8;
	localparam logic [3:0]  XPF_B_IDX     = 4'h9;
	localparam logic [3:0]  YPF_A_IDX     = 4'hA;
	localparam logic [3:0]  YPF_B_IDX     = 4'hB;
	localparam int unsigned FILE_AW       = 13;
	localparam int unsigned SHORT_LIT_W   = 5;
	localparam int unsigned OFFS_REG_W    = 4;
	localparam logic [15:0] CIRC_RST      = 16'h0000;
	localparam logic [3:0]  CIRC_SEL_RST  = 4'hF;

	typedef enum logic [3:0] {
		EAG_AM_DIRECT,
		EAG_AM_FILE,
		EAG_AM_IND,
		EAG_AM_POST,
		EAG_AM_PRE,
		EAG_AM_REGOFF,
		EAG_AM_LITOFF,
		EAG_AM_LIT5,
		EAG_AM_LIT8,
		EAG_AM_LIT16,
		EAG_AM_DSP
	} eag_mode_e;

	typedef enum logic [1:0] {
		EAG_STK_NONE,
		EAG_STK_PUSH,
		EAG_STK_POP
	} eag_stk_e;

	typedef struct packed {
		logic        valid;
		eag_mode_e   mode;
		logic [3:0]  ptr;
		logic [3:0]  offs;
		logic [15:0] lit;
		logic [12:0] faddr;
		logic        byte_op;
		logic        y_space;
	} eag_req_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] ea;
		logic        wb_en;
		logic [3:0]  wb_idx;
		logic [15:0] wb_val;
		logic        lit_valid;
		logic [15:0] lit_val;
	} eag_rsp_s;

endpackage : eag_pkg

//--- tb/eag_mem_model.sv
// eag_mem_model: stack-side data memory behind the push/pop ports
// assumes word-aligned stack addresses; 256 words are enough for the bench
`timescale 1ns/1ps
module eag_mem_model (
	input  wire logic        clk_sys_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] data_i,
	output logic      [15:0] rd_data_o
);
	logic [15:0] mem_q [256];
	logic [15:0] last_q = 16'h0000;
	// idle bus shows the inverse of the last word, so a stale copy never passes
	assign rd_data_o = rd_i ? mem_q[addr_i[8:1]] : ~last_q;
	always_ff @(posedge clk_sys_i) begin
		if (wr_i) mem_q[addr_i[8:1]] <= data_i;
		if (rd_i) last_q <= mem_q[addr_i[8:1]];
	end
endmodule : eag_mem_model

//--- tb/tb.sv
// tb: stack, address forming and circular wrap against an integer model
// assumes one request or stack op at a time; inputs move 1 ns after the edge
`timescale 1ns/1ps
module tb;
	logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, stk_call_i = 1'b0, stk_exc_i = 1'b0, ys = 1'b0;
	logic reg_wr_i = 1'b0, stack_limit_wr_i = 1'b0, circ_wr_i = 1'b0, x_circ_en_i = 1'b0, y_circ_en_i = 1'b0;
	logic [3:0] reg_wr_idx_i = '0, x_circ_pointer_select_i = 4'hF, y_circ_pointer_select_i = 4'hF;
	logic [15:0] reg_wr_data_i = '0, stack_limit_data_i = '0, circ_wr_data_i = '0, w [16], l, s;
	logic [1:0] circ_wr_sel_i = '0;
	logic [22:0] pc_i = '0;
	logic [7:0] status_low_byte_i = '0;
	logic [12:0] fa = '0;
	eag_pkg::eag_req_s req_i = '0;
	eag_pkg::eag_stk_e stk_op_i = eag_pkg::EAG_STK_NONE;
	eag_pkg::eag_rsp_s rsp_o;
	logic stk_wr_o, stk_rd_o, stack_trap_o, req_reject_o;
	logic [15:0] stk_addr_o, stk_data_o, stack_pointer_reg_o, stack_limit_reg_o, mem_rd;
	logic [15:0] stq [$];
	int failures = 0, tests_run = 0, sp, i;
	integer seed = 32'h983a;
	always #12.5 clk_sys_i = ~clk_sys_i;
	eag_top dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .stk_op_i(stk_op_i),
		.stk_call_i(stk_call_i), .stk_exc_i(stk_exc_i), .pc_i(pc_i), .status_low_byte_i(status_low_byte_i),
		.reg_wr_i(reg_wr_i), .reg_wr_idx_i(reg_wr_idx_i), .reg_wr_data_i(reg_wr_data_i),
		.stack_limit_wr_i(stack_limit_wr_i), .stack_limit_data_i(stack_limit_data_i), .circ_wr_i(circ_wr_i),
		.circ_wr_sel_i(circ_wr_sel_i), .circ_wr_data_i(circ_wr_data_i), .x_circ_en_i(x_circ_en_i),
		.y_circ_en_i(y_circ_en_i), .x_circ_pointer_select_i(x_circ_pointer_select_i),
		.y_circ_pointer_select_i(y_circ_pointer_select_i), .rsp_o(rsp_o), .stk_wr_o(stk_wr_o), .stk_rd_o(stk_rd_o),
		.stk_addr_o(stk_addr_o), .stk_data_o(stk_data_o), .stack_trap_o(stack_trap_o), .req_reject_o(req_reject_o),
		.stack_pointer_reg_o(stack_pointer_reg_o), .stack_limit_reg_o(stack_limit_reg_o));
	eag_mem_model mem (.clk_sys_i(clk_sys_i), .wr_i(stk_wr_o), .rd_i(stk_rd_o), .addr_i(stk_addr_o),
		.data_i(stk_data_o), .rd_data_o(mem_rd));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic step();
		@(posedge clk_sys_i);
		#1;
	endtask : step
	task automatic summarize();
		$display("comparisons=%0d mismatches=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	task automatic rst(input int n);
		sys_rst_i = 1'b1;
		repeat (n) step();
		sys_rst_i = 1'b0;
		sp = 16'h0800;
		stq.delete();
		w = '{default: 16'h0000};
		chk(stack_pointer_reg_o, 16'h0800);
	endtask : rst
	// held high between calls; rq lowers it, so no signal moves twice per step
	task automatic wreg(input logic [3:0] idx, input logic [15:0] d);
		reg_wr_i = 1'b1;
		reg_wr_idx_i = idx;
		reg_wr_data_i = d;
		w[idx] = d;
		step();
	endtask : wreg
	task automatic cwr(input logic [1:0] sel, input logic [15:0] d);
		circ_wr_i = 1'b1;
		circ_wr_sel_i = sel;
		circ_wr_data_i = d;
		step();
	endtask : cwr
	task automatic stk(input eag_pkg::eag_stk_e op, input logic call, input logic exc, input logic trap);
		logic [15:0] d;
		stk_op_i = op;
		stk_call_i = call;
		stk_exc_i = exc;
		pc_i = 23'($random(seed));
		status_low_byte_i = 8'($random(seed));
		d = exc ? {status_low_byte_i, 1'b0, pc_i[22:16]} : (call ? {9'h000, pc_i[22:16]} : 16'h0000);
		#1;
		chk(stack_trap_o, trap);
		chk(stk_wr_o, op == eag_pkg::EAG_STK_PUSH);
		chk(stk_rd_o, op == eag_pkg::EAG_STK_POP);
		if (op == eag_pkg::EAG_STK_PUSH) begin
			chk(stk_addr_o, 16'(sp));
			chk(stk_data_o, d);
			stq.push_back(d);
			sp += 2;
		end else begin
			chk(stk_addr_o, 16'(sp - 2));
			if (!trap) chk(mem_rd, stq.pop_back());
			sp -= 2;
		end
		step();
		if (!trap) chk(stack_pointer_reg_o, 16'(sp));
	endtask : stk
	task automatic rq(input eag_pkg::eag_mode_e m, input logic [3:0] p, input logic [15:0] lv,
		input logic [15:0] ea, input logic wb, input logic [15:0] wv, input logic rj);
		reg_wr_i = 1'b0;
		circ_wr_i = 1'b0;
		req_i = '{valid: 1'b1, mode: m, ptr: p, offs: 4'h4, lit: lv, faddr: fa, byte_op: 1'b0, y_space: ys};
		#1;
		chk(req_reject_o, rj);
		chk(stack_trap_o, p == 4'hF && !rj && (ea > 16'h0804 || ea < 16'h0800));
		step();
		req_i.valid = 1'b0;
		chk(rsp_o.valid, !rj);
		if (!rj) chk(rsp_o.lit_valid, m >= eag_pkg::EAG_AM_LIT5 && m <= eag_pkg::EAG_AM_LIT16);
		if (!rj && m >= eag_pkg::EAG_AM_LIT5 && m <= eag_pkg::EAG_AM_LIT16)
			chk(rsp_o.lit_val, ea);
		else if (!rj) begin
			chk(rsp_o.ea, ea);
			chk(rsp_o.wb_en, wb);
			if (wb) chk(rsp_o.wb_val, wv);
			if (wb) chk(rsp_o.wb_idx, p);
			if (wb) w[p] = wv;
		end
		step();
	endtask : rq
	initial begin
		rst(16);
		stack_limit_wr_i = 1'b1;
		stack_limit_data_i = 16'h0805;
		step();
		stack_limit_wr_i = 1'b0;
		chk(stack_limit_reg_o, 16'h0804);
		step();
		stk(eag_pkg::EAG_STK_PUSH, 1'b1, 1'b0, 1'b0);
		stk(eag_pkg::EAG_STK_POP, 1'b0, 1'b0, 1'b0);
		stk(eag_pkg::EAG_STK_POP, 1'b0, 1'b0, 1'b1);
		stk_op_i = eag_pkg::EAG_STK_NONE;
		rst(2);
		stk(eag_pkg::EAG_STK_PUSH, 1'b0, 1'b1, 1'b0);
		stk(eag_pkg::EAG_STK_PUSH, 1'b1, 1'b0, 1'b0);
		stk(eag_pkg::EAG_STK_PUSH, 1'b0, 1'b0, 1'b0);
		stk(eag_pkg::EAG_STK_PUSH, 1'b0, 1'b0, 1'b1);
		stk_op_i = eag_pkg::EAG_STK_NONE;
		step();
		chk(stack_trap_o, 1'b0);
		rst(2);
		$display("stack test done");
		wreg(3, 16'h1000 | (16'($random(seed)) & 16'h0FFE));
		wreg(4, 16'h0002);
		rq(eag_pkg::EAG_AM_LITOFF, 15, 16'h0006, 16'h0806, 1'b0, 16'h0000, 1'b0);
		rq(eag_pkg::EAG_AM_PRE, 15, 16'h0006, 16'h0806, 1'b1, 16'h0806, 1'b0);
		rq(eag_pkg::EAG_AM_IND, 15, 16'h0000, 16'h0806, 1'b0, 16'h0000, 1'b0);
		rq(eag_pkg::EAG_AM_PRE, 15, 16'h0010, 16'h07F6, 1'b1, 16'h07F6, 1'b0);
		for (i = 0; i < 4; i++) begin
			l = 16'($random(seed));
			s = {{11{l[4]}}, l[4:0]};
			rq(eag_pkg::EAG_AM_POST, 3, l, w[3], 1'b1, w[3] + s, 1'b0);
			rq(eag_pkg::EAG_AM_PRE, 3, l, w[3] + s, 1'b1, w[3] + s, 1'b0);
		end
		fa = 13'($random(seed));
		rq(eag_pkg::EAG_AM_IND, 3, l, w[3], 1'b0, 16'h0000, 1'b0);
		rq(eag_pkg::EAG_AM_REGOFF, 3, l, w[3] + w[4], 1'b0, 16'h0000, 1'b0);
		rq(eag_pkg::EAG_AM_LITOFF, 3, 16'h0006, w[3] + 16'h0006, 1'b0, 16'h0000, 1'b0);
		rq(eag_pkg::EAG_AM_FILE, 0, l, {3'b000, fa}, 1'b0, 16'h0000, 1'b0);
		rq(eag_pkg::EAG_AM_LIT5, 0, l, {11'h000, l[4:0]}, 1'b0, 16'h0000, 1'b0);
		rq(eag_pkg::EAG_AM_LIT16, 0, l, l, 1'b0, 16'h0000, 1'b0);
		rq(eag_pkg::EAG_AM_LIT8, 0, l, {8'h00, l[7:0]}, 1'b0, 16'h0000, 1'b0);
		rq(eag_pkg::EAG_AM_DIRECT, 3, l, w[3], 1'b0, 16'h0000, 1'b0);
		for (i = 8; i < 12; i++) wreg(4'(i), 16'h1800 + 16'(i * 16));
		for (i = 0; i < 4; i++) rq(eag_pkg::EAG_AM_DSP, 4'(8 + i), 16'(i), w[8 + i], i != 0, w[8 + i] + 16'(2 * i), 1'b0);
		rq(eag_pkg::EAG_AM_DSP, 7, 16'h0000, 16'h0000, 1'b0, 16'h0000, 1'b1);
		rq(eag_pkg::EAG_AM_DSP, 8, 16'h0004, 16'h0000, 1'b0, 16'h0000, 1'b1);
		rq(eag_pkg::EAG_AM_DSP, 10, 16'h0004, 16'h0000, 1'b0, 16'h0000, 1'b1);
		rq(eag_pkg::EAG_AM_DSP, 9, 16'h0004, w[9] + w[4], 1'b0, 16'h0000, 1'b0);
		$display("address test done");
		cwr(0, 16'h1000);
		cwr(1, 16'h1007);
		cwr(2, 16'h2000);
		cwr(3, 16'h2007);
		x_circ_en_i = 1'b1;
		y_circ_en_i = 1'b1;
		x_circ_pointer_select_i = 4'h3;
		y_circ_pointer_select_i = 4'h5;
		wreg(3, 16'h1006);
		wreg(5, 16'h2006);
		rq(eag_pkg::EAG_AM_POST, 3, 16'h0002, 16'h1006, 1'b1, 16'h1000, 1'b0);
		wreg(3, 16'h1006);
		rq(eag_pkg::EAG_AM_REGOFF, 3, 16'h0000, 16'h1000, 1'b0, 16'h0000, 1'b0);
		wreg(3, 16'h1000);
		rq(eag_pkg::EAG_AM_PRE, 3, 16'h001E, 16'h1006, 1'b1, 16'h1006, 1'b0);
		ys = 1'b1;
		rq(eag_pkg::EAG_AM_POST, 5, 16'h0002, 16'h2006, 1'b1, 16'h2000, 1'b0);
		wreg(5, 16'h2003);
		rq(eag_pkg::EAG_AM_IND, 5, 16'h0000, 16'h2002, 1'b0, 16'h0000, 1'b0);
		ys = 1'b0;
		x_circ_pointer_select_i = 4'hF;
		wreg(3, 16'h1006);
		rq(eag_pkg::EAG_AM_POST, 3, 16'h0002, 16'h1006, 1'b1, 16'h1008, 1'b0);
		$display("circular test done");
		summarize();
	end
	// about 115 cycles of work; a hang past 2000 ends the run
	initial begin
		repeat (2000) @(posedge clk_sys_i);
		failures++;
		summarize();
	end
endmodule : tb
